// File: pressure_link_pkg.sv
// Shared constants and types of the pressure sensor host link
package pressure_link_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ           = 40_000_000;
	localparam int unsigned T_STRETCH_TYP_US = 15;
	localparam int unsigned T_STRETCH_MAX_US = 100;
	localparam int unsigned STRETCH_TYP_CYC  = T_STRETCH_TYP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned STRETCH_MAX_CYC  = T_STRETCH_MAX_US * (CLK_HZ / 1_000_000);
	localparam int unsigned T_STARTUP_MS     = 80;
	localparam int unsigned STARTUP_CYC      = T_STARTUP_MS * (CLK_HZ / 1000);
	localparam int unsigned T_IO_DELAY_US    = 1000;
	localparam int unsigned IO_DELAY_CYC     = T_IO_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned WDOG_UNIT_CYC    = CLK_HZ / 1000;
	// Control register reset values and field positions
	localparam logic [7:0] MODE_RESET     = 8'hf6;
	localparam logic [7:0] RATE_RESET     = 8'h00;
	localparam int unsigned MODE_RANGE_LSB = 0;
	localparam int unsigned MODE_WDOG_BIT  = 3;
	localparam int unsigned MODE_BW_LSB    = 4;
	localparam int unsigned MODE_NOTCH_BIT = 7;
	// Two-wire address strap
	localparam logic [6:0] ADDR_BASE      = 7'h28;
	localparam logic [6:0] ADDR_MAX       = 7'h31;
	localparam logic [3:0] ADDR_LEVEL_MAX = 4'h9;
	// Read sequence byte positions
	localparam logic [4:0] NUM_CTRL_BYTES = 5'h02;
	localparam logic [4:0] IDX_TEMP       = 5'h02;
	localparam logic [4:0] IDX_MODEL      = 5'h04;
	localparam logic [4:0] IDX_SERIAL     = 5'h0c;
	localparam logic [4:0] IDX_BUILD      = 5'h10;
	localparam logic [4:0] XFER_BYTES     = 5'h16;
	localparam logic [7:0] UNDEF_BYTE     = 8'hff;
	// 0.9 in Q1.15, places full scale at 90 percent of the code range
	localparam logic signed [15:0] FS_90_Q15 = 16'sh7333;
	// Automatic pacing divisors of the 444 Hz tick, one per bandwidth code
	localparam logic [7:0] AUTO_DIV [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h25, 8'h4a, 8'h94};

	// Mode control byte, bit 7 down to bit 0
	typedef struct packed {
		logic       notch;
		logic [2:0] bandwidth_limit_field;
		logic       wdog;
		logic [2:0] range;
	} mode_t;

	typedef struct packed {
		logic [15:0] pressure;
		logic [15:0] temperature;
	} sample_t;
endpackage

// File: pin_sync.sv
// Two flip-flop synchroniser for pin inputs
module pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;
endmodule

// File: sample_buffer.sv
// Small valid/ready FIFO between acquisition and the serial ports
module sample_buffer #(
	parameter int unsigned W     = 32,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic          push;
	logic          pop;

	assign in_ready_o  = (count_reg != CW'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// File: pressure_link.sv
// Serial host link of the pressure sensor: two-wire and four-wire slave ports
module pressure_link #(
	parameter int unsigned          STARTUP_CYC_P  = pressure_link_pkg::STARTUP_CYC,
	parameter int unsigned          IO_DELAY_CYC_P = pressure_link_pkg::IO_DELAY_CYC,
	parameter int unsigned          WDOG_UNIT_P    = pressure_link_pkg::WDOG_UNIT_CYC,
	parameter logic [63:0]          MODEL_ID       = 64'h5053_3031_0000_0000, // Arbitrary value
	parameter logic [31:0]          SERIAL_ID      = 32'h0000_0001,           // Arbitrary value
	parameter logic [47:0]          BUILD_ID       = 48'h3030_3031_4100       // Arbitrary value
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      port_select_n_i,
	input  wire logic                      scl_mosi_i,
	output logic                           scl_o,
	output logic                           scl_oe_o,
	input  wire logic                      sda_miso_i,
	output logic                           sda_o,
	output logic                           sda_oe_o,
	input  wire logic                      sck_i,
	input  wire logic [3:0]                addr_level_i,
	input  wire logic                      sample_tick_i,
	input  wire logic signed [15:0]        raw_pressure_i,
	input  wire logic [15:0]               temperature_i,
	output logic                           acq_ready_o,
	output logic                           sample_ready_pin_o,
	output logic                           settled_o,
	output logic                           self_reset_o,
	output pressure_link_pkg::mode_t       measurement_config_o
);
	import pressure_link_pkg::*;

	typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK, ST_STR, ST_SPI} link_state_t;

	logic [7:0]  pin_s;
	logic [3:0]  pin_q_reg;
	logic        nss_s, scl_s, sda_s, sck_s;
	logic [3:0]  level_s;
	logic        nss_fall, scl_rise, scl_fall, sck_rise, sck_fall, start_c, stop_c, activity;
	logic [31:0] boot_cnt_reg;
	logic        iface_on_reg, spi_sel_reg, settled_reg;
	logic [6:0]  addr_reg;
	mode_t       mode_wr_reg, mode_stage_reg, mode_act_reg;
	logic [7:0]  rate_reg, div_cnt_reg, divisor;
	logic        dav_reg, dav_fire;
	logic [31:0] wd_cnt_reg, wd_limit;
	logic        soft_rst_reg;
	link_state_t st_reg, ret_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  sh_reg, tx_reg, ctrl_byte_reg, byte0, byte_nx;
	logic [4:0]  idx_reg, idx_nx;
	logic        rw_reg, long_done_reg, ctrl_we_reg, ctrl_sel_reg, sda_oe_reg, scl_oe_reg;
	logic [11:0] str_cnt_reg;
	sample_t     snap_reg, cur, buf_data, in_sample;
	logic        buf_valid, read_go;

	// Address from the quantised strap level, clamped to the top entry
	function automatic logic [6:0] strap_addr(input logic [3:0] lvl);
		logic [3:0] l;
		l = (lvl > ADDR_LEVEL_MAX) ? ADDR_LEVEL_MAX : lvl;
		return ADDR_BASE + {3'b000, l};
	endfunction

	// Output full scale at 90 percent of the code range
	function automatic logic [15:0] scale_fs(input logic signed [15:0] raw);
		logic signed [31:0] p;
		p = raw * FS_90_Q15;
		return p[30:15];
	endfunction

	// Byte of the read sequence at a given position
	function automatic logic [7:0] get_byte(input logic [4:0] i, input sample_t s);
		logic [4:0] k;
		k = 5'h00;
		if (i < IDX_TEMP) begin
			return i[0] ? s.pressure[7:0] : s.pressure[15:8];
		end else if (i < IDX_MODEL) begin
			return i[0] ? s.temperature[7:0] : s.temperature[15:8];
		end else if (i < IDX_SERIAL) begin
			k = i - IDX_MODEL;
			return MODEL_ID[8*(7-k) +: 8];
		end else if (i < IDX_BUILD) begin
			k = i - IDX_SERIAL;
			return SERIAL_ID[8*(3-k) +: 8];
		end else if (i < XFER_BYTES) begin
			k = i - IDX_BUILD;
			return BUILD_ID[8*(5-k) +: 8];
		end
		return UNDEF_BYTE;
	endfunction

	pin_sync #(.W(8)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({addr_level_i, sck_i, sda_miso_i, scl_mosi_i, port_select_n_i}),
		.q_o   (pin_s)
	);

	assign in_sample = '{pressure: scale_fs(raw_pressure_i), temperature: temperature_i};

	sample_buffer #(.W($bits(sample_t)), .DEPTH(2)) u_buf (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (sample_tick_i),
		.in_ready_o  (acq_ready_o),
		.in_data_i   (in_sample),
		.out_valid_o (buf_valid),
		.out_ready_i (read_go),
		.out_data_o  (buf_data)
	);

	// Pin edges on the synchronised levels
	assign {level_s, sck_s, sda_s, scl_s, nss_s} = pin_s;
	assign nss_fall = pin_q_reg[0] && !nss_s;
	assign scl_rise = !pin_q_reg[1] && scl_s;
	assign scl_fall = pin_q_reg[1] && !scl_s;
	assign sck_rise = !pin_q_reg[3] && sck_s;
	assign sck_fall = pin_q_reg[3] && !sck_s;
	assign start_c  = scl_s && pin_q_reg[1] && pin_q_reg[2] && !sda_s;
	assign stop_c   = scl_s && pin_q_reg[1] && !pin_q_reg[2] && sda_s;
	assign activity = (pin_q_reg[0] ^ nss_s) || (pin_q_reg[1] ^ scl_s) || (pin_q_reg[3] ^ sck_s);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_q_reg <= 4'hf;
		end else begin
			pin_q_reg <= pin_s[3:0];
		end
	end

	// Start of a read: select drop on four-wire, end of read address ack on two-wire
	assign cur     = buf_valid ? buf_data : snap_reg;
	assign byte0   = get_byte(5'h00, cur);
	assign idx_nx  = (idx_reg == 5'h1f) ? idx_reg : idx_reg + 5'h01;
	assign byte_nx = get_byte(idx_nx, snap_reg);
	assign read_go = iface_on_reg && !soft_rst_reg && (spi_sel_reg ? nss_fall
		: (st_reg == ST_AACK && scl_fall && rw_reg && !start_c && !stop_c));

	// Start-up delay, port selection and strap capture
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			boot_cnt_reg <= '0;
			iface_on_reg <= 1'b0;
			spi_sel_reg  <= 1'b0;
			addr_reg     <= ADDR_BASE;
			settled_reg  <= 1'b0;
		end else if (soft_rst_reg) begin
			boot_cnt_reg <= '0;
			iface_on_reg <= 1'b0;
			spi_sel_reg  <= 1'b0;
			addr_reg     <= ADDR_BASE;
			settled_reg  <= 1'b0;
		end else begin
			if (boot_cnt_reg != STARTUP_CYC_P) begin
				boot_cnt_reg <= boot_cnt_reg + 32'd1;
			end
			if (!iface_on_reg && boot_cnt_reg >= IO_DELAY_CYC_P) begin
				iface_on_reg <= 1'b1;
				spi_sel_reg  <= nss_s;
				addr_reg     <= strap_addr(level_s);
			end
			settled_reg <= (boot_cnt_reg == STARTUP_CYC_P);
		end
	end

	// Control registers with two-read latency on the active mode
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_wr_reg    <= mode_t'(MODE_RESET);
			mode_stage_reg <= mode_t'(MODE_RESET);
			mode_act_reg   <= mode_t'(MODE_RESET);
			rate_reg       <= RATE_RESET;
		end else if (soft_rst_reg) begin
			mode_wr_reg    <= mode_t'(MODE_RESET);
			mode_stage_reg <= mode_t'(MODE_RESET);
			mode_act_reg   <= mode_t'(MODE_RESET);
			rate_reg       <= RATE_RESET;
		end else begin
			if (ctrl_we_reg && !ctrl_sel_reg) begin
				mode_wr_reg <= mode_t'(ctrl_byte_reg);
			end
			if (ctrl_we_reg && ctrl_sel_reg) begin
				rate_reg <= ctrl_byte_reg;
			end
			if (read_go) begin
				mode_stage_reg <= mode_wr_reg;
				mode_act_reg   <= mode_stage_reg;
			end
		end
	end

	// Ready pacing divider of the update tick
	assign divisor  = (rate_reg != 8'h00) ? rate_reg : AUTO_DIV[mode_act_reg.bandwidth_limit_field];
	assign dav_fire = sample_tick_i && (div_cnt_reg <= 8'h01);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_reg <= 8'h00;
			dav_reg     <= 1'b0;
		end else begin
			if (dav_fire) begin
				div_cnt_reg <= divisor;
			end else if (sample_tick_i) begin
				div_cnt_reg <= div_cnt_reg - 8'h01;
			end
			if (dav_fire) begin
				dav_reg <= 1'b1;
			end else if (read_go) begin
				dav_reg <= 1'b0;
			end
		end
	end

	// Link watchdog, timeout doubles per bandwidth code
	assign wd_limit = WDOG_UNIT_P << mode_act_reg.bandwidth_limit_field;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wd_cnt_reg   <= '0;
			soft_rst_reg <= 1'b0;
		end else begin
			if (!mode_act_reg.wdog || activity || soft_rst_reg) begin
				wd_cnt_reg <= '0;
			end else begin
				wd_cnt_reg <= wd_cnt_reg + 32'd1;
			end
			soft_rst_reg <= mode_act_reg.wdog && !activity && !soft_rst_reg && (wd_cnt_reg >= wd_limit);
		end
	end

	// Held sample for the bytes after the first
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			snap_reg <= '0;
		end else if (read_go && buf_valid) begin
			snap_reg <= buf_data;
		end
	end

	// Serial engine: four-wire shift or two-wire slave state machine
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= ST_IDLE;
			ret_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			idx_reg <= 5'h00;
			rw_reg <= 1'b0;
			long_done_reg <= 1'b0;
			str_cnt_reg <= 12'h000;
			ctrl_we_reg <= 1'b0;
			ctrl_sel_reg <= 1'b0;
			ctrl_byte_reg <= 8'h00;
			sda_oe_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
		end else begin
			ctrl_we_reg <= 1'b0;
			if (soft_rst_reg || !iface_on_reg) begin
				st_reg <= ST_IDLE;
				sda_oe_reg <= 1'b0;
				scl_oe_reg <= 1'b0;
			end else if (spi_sel_reg) begin
				scl_oe_reg <= 1'b0;
				if (nss_s) begin
					st_reg <= ST_IDLE;
					sda_oe_reg <= 1'b0;
				end else if (nss_fall) begin
					st_reg <= ST_SPI;
					idx_reg <= 5'h00;
					bit_reg <= 4'h0;
					tx_reg <= byte0;
					sda_oe_reg <= 1'b1;
				end else if (st_reg == ST_SPI && sck_rise) begin
					sh_reg <= {sh_reg[6:0], scl_s};
					bit_reg <= bit_reg + 4'h1;
					if (bit_reg == 4'h7) begin
						ctrl_we_reg <= (idx_reg < NUM_CTRL_BYTES);
						ctrl_sel_reg <= idx_reg[0];
						ctrl_byte_reg <= {sh_reg[6:0], scl_s};
						idx_reg <= idx_nx;
					end
				end else if (st_reg == ST_SPI && sck_fall) begin
					if (bit_reg == 4'h8) begin
						bit_reg <= 4'h0;
						tx_reg <= get_byte(idx_reg, snap_reg);
					end else begin
						tx_reg <= {tx_reg[6:0], 1'b0};
					end
				end
			end else if (start_c) begin
				st_reg <= ST_ADDR;
				bit_reg <= 4'h0;
				long_done_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
				scl_oe_reg <= 1'b0;
			end else if (stop_c) begin
				st_reg <= ST_IDLE;
				sda_oe_reg <= 1'b0;
				scl_oe_reg <= 1'b0;
			end else begin
				case (st_reg)
					ST_ADDR, ST_WR: begin
						if (scl_rise) begin
							sh_reg <= {sh_reg[6:0], sda_s};
							bit_reg <= bit_reg + 4'h1;
						end else if (scl_fall && bit_reg == 4'h8) begin
							bit_reg <= 4'h0;
							if (st_reg == ST_WR) begin
								ctrl_we_reg <= (idx_reg < NUM_CTRL_BYTES);
								ctrl_sel_reg <= idx_reg[0];
								ctrl_byte_reg <= sh_reg;
								idx_reg <= idx_nx;
								sda_oe_reg <= 1'b1;
								st_reg <= ST_WACK;
							end else if (sh_reg[7:1] == addr_reg) begin
								rw_reg <= sh_reg[0];
								idx_reg <= 5'h00;
								sda_oe_reg <= 1'b1;
								st_reg <= ST_AACK;
							end else begin
								st_reg <= ST_IDLE;
							end
						end
					end
					ST_AACK, ST_WACK: begin
						if (scl_fall) begin
							scl_oe_reg <= 1'b1;
							str_cnt_reg <= long_done_reg ? 12'(STRETCH_TYP_CYC - 1) : 12'(STRETCH_MAX_CYC - 1);
							long_done_reg <= 1'b1;
							st_reg <= ST_STR;
							ret_reg <= (st_reg == ST_AACK && rw_reg) ? ST_RD : ST_WR;
							tx_reg <= byte0;
							sda_oe_reg <= (st_reg == ST_AACK && rw_reg) && !byte0[7];
						end
					end
					ST_STR: begin
						if (str_cnt_reg == 12'h000) begin
							scl_oe_reg <= 1'b0;
							st_reg <= ret_reg;
						end else begin
							str_cnt_reg <= str_cnt_reg - 12'h001;
						end
					end
					ST_RD: begin
						if (scl_fall) begin
							if (bit_reg == 4'h7) begin
								bit_reg <= 4'h0;
								sda_oe_reg <= 1'b0;
								st_reg <= ST_RACK;
							end else begin
								bit_reg <= bit_reg + 4'h1;
								tx_reg <= {tx_reg[6:0], 1'b0};
								sda_oe_reg <= !tx_reg[6];
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							sh_reg <= {sh_reg[6:0], sda_s};
						end else if (scl_fall) begin
							if (!sh_reg[0]) begin
								idx_reg <= idx_nx;
								tx_reg <= byte_nx;
								sda_oe_reg <= !byte_nx[7];
								scl_oe_reg <= 1'b1;
								str_cnt_reg <= long_done_reg ? 12'(STRETCH_TYP_CYC - 1) : 12'(STRETCH_MAX_CYC - 1);
								long_done_reg <= 1'b1;
								ret_reg <= ST_RD;
								st_reg <= ST_STR;
							end else begin
								st_reg <= ST_IDLE;
							end
						end
					end
					default: begin
						sda_oe_reg <= 1'b0;
						scl_oe_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// Pins and status outputs
	assign scl_o                = 1'b0;
	assign scl_oe_o             = scl_oe_reg;
	assign sda_o                = spi_sel_reg ? tx_reg[7] : 1'b0;
	assign sda_oe_o             = sda_oe_reg;
	assign sample_ready_pin_o   = dav_reg;
	assign settled_o            = settled_reg;
	assign self_reset_o         = soft_rst_reg;
	assign measurement_config_o = mode_act_reg;

	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ADDR_DEFAULT: assert property ($rose(iface_on_reg) && $past(level_s) == 4'h0 |-> addr_reg == ADDR_BASE)
		else $error("strap at ground did not give base address");
	AST_ADDR_RANGE: assert property (iface_on_reg |-> addr_reg >= ADDR_BASE && addr_reg <= ADDR_MAX)
		else $error("slave address out of strap range");
	AST_NO_SPI_SCL: assert property (spi_sel_reg |-> !scl_oe_o)
		else $error("clock line driven on four-wire port");
	AST_STRETCH_ONLY: assert property (scl_oe_o |-> st_reg == ST_STR && !spi_sel_reg)
		else $error("clock held low outside a stretch");
	AST_LONG_ONCE: assert property ($rose(scl_oe_reg) && str_cnt_reg == 12'(STRETCH_MAX_CYC - 1) |-> !$past(long_done_reg))
		else $error("second long stretch in one transaction");
	AST_CTRL_FIRST_TWO: assert property (ctrl_we_reg |-> idx_reg >= 5'h01 && idx_reg <= NUM_CTRL_BYTES)
		else $error("control written from a late byte");
	AST_MODE_LATENCY: assert property ($changed(mode_act_reg) |-> $past(read_go) || $past(soft_rst_reg))
		else $error("active mode changed outside a read start");
	AST_DAV_CLEAR: assert property (read_go && !dav_fire |=> !sample_ready_pin_o)
		else $error("ready pin not cleared by pressure read");
	AST_RATE_RELOAD: assert property (dav_fire |=> div_cnt_reg == $past(divisor) && sample_ready_pin_o)
		else $error("divider not reloaded on ready");
	AST_WDOG_CAUSE: assert property (self_reset_o |-> $past(mode_act_reg.wdog) && $past(wd_cnt_reg) >= $past(wd_limit))
		else $error("self reset without watchdog timeout");

	COV_SPI_READ: cover property (spi_sel_reg && read_go ##[1:1000] ctrl_we_reg);
	COV_I2C_LONG: cover property ($rose(scl_oe_reg) && str_cnt_reg == 12'(STRETCH_MAX_CYC - 1));
	COV_WDOG: cover property (self_reset_o);
	COV_DAV: cover property (dav_fire ##[1:1000] read_go);
endmodule

// File: spi_host.sv
// Four-wire host model that clocks framed transfers into the link
module spi_host (
	input  wire logic    clk_i,
	input  wire logic    miso_i,
	output logic         nss_o,
	output logic         sck_o,
	output logic         mosi_o,
	output logic [175:0] rx_o,
	output logic         done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus: deselected, clock parked low
	initial begin
		nss_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b0;
		rx_o = '0;
		done_o = 1'b0;
	end
	// One frame of nb bytes: control word, then filler bytes
	task automatic xfer(input int nb, input logic [15:0] ctl, input logic [7:0] fill);
		logic [7:0] tx;
		rx_o = '1;
		@(posedge clk_i) #1 nss_o = 1'b0;
		repeat (12) @(posedge clk_i);
		for (int b = 0; b < nb; b++) begin
			tx = (b == 0) ? ctl[15:8] : (b == 1) ? ctl[7:0] : fill;
			for (int i = 7; i >= 0; i--) begin
				#1 mosi_o = tx[i];
				repeat (4) @(posedge clk_i);
				#1 sck_o = 1'b1;
				rx_o = {rx_o[174:0], miso_i};
				repeat (4) @(posedge clk_i);
				#1 sck_o = 1'b0;
			end
		end
		repeat (20) @(posedge clk_i);
		#1 nss_o = 1'b1;
		mosi_o = ~mosi_o; // Released line keeps no stale value
		done_o = 1'b1;
		@(posedge clk_i) #1 done_o = 1'b0;
	endtask
endmodule

// File: tb_top.sv
// Self-checking bench: host model sends frames, monitor compares replies
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pressure_link_pkg::*;
	localparam logic [63:0] MODEL  = 64'h4142_4330_0000_0000; // Arbitrary value
	localparam logic [31:0] SERIAL = 32'h1234_5678;           // Arbitrary value
	localparam logic [47:0] BUILD  = 48'h3031_3233_4400;      // Arbitrary value
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic tick = 1'b0;
	logic port_select_n, sck, mosi, miso, done, sda, sda_oe, settled, ready, wdrst;
	logic signed [15:0] raw;
	logic [15:0] temp;
	logic [3:0] lvl;
	logic [175:0] rx;
	logic [175:0] exp_q[$];
	int nb_q[$];
	int errors = 0;
	int n_checks = 0;
	int seed = 32'hf789;
	logic signed [31:0] prod;
	mode_t cfg, cfg2, cfg_o;
	always #12.5 clk_i = ~clk_i;
	assign miso = sda_oe ? sda : 1'b1;
	spi_host i_host (.clk_i(clk_i), .miso_i(miso), .nss_o(port_select_n), .sck_o(sck), .mosi_o(mosi), .rx_o(rx), .done_o(done));
	pressure_link #(.STARTUP_CYC_P(200), .IO_DELAY_CYC_P(50), .WDOG_UNIT_P(100), .MODEL_ID(MODEL),
		.SERIAL_ID(SERIAL), .BUILD_ID(BUILD)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .port_select_n_i(port_select_n),
		.scl_mosi_i(mosi), .scl_o(), .scl_oe_o(), .sda_miso_i(1'b1), .sda_o(sda), .sda_oe_o(sda_oe),
		.sck_i(sck), .addr_level_i(lvl), .sample_tick_i(tick), .raw_pressure_i(raw), .temperature_i(temp),
		.acq_ready_o(), .sample_ready_pin_o(ready), .settled_o(settled), .self_reset_o(wdrst),
		.measurement_config_o(cfg_o));
	// Update tick every 500 cycles
	always begin
		repeat (499) @(posedge clk_i);
		#1 tick = 1'b1;
		@(posedge clk_i) #1 tick = 1'b0;
	end
	task automatic check(input string what, input logic [175:0] seen, input logic [175:0] want);
		n_checks++;
		if (seen !== want) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Note the expected reply, then run the frame
	task automatic frame(input int nb, input bit chk, input logic [7:0] m, input logic [7:0] r);
		exp_q.push_back({prod[30:15], temp, MODEL, SERIAL, BUILD});
		nb_q.push_back(chk ? nb : 0);
		i_host.xfer(nb, {m, r}, 8'($random(seed)));
	endtask
	// Reply monitor: oldest note against each completed frame
	always @(posedge clk_i) begin
		if (done === 1'b1) begin
			check("frame", rx & ({176{1'b1}} >> (176 - 8 * nb_q[0])), exp_q[0] >> (176 - 8 * nb_q[0]));
			void'(exp_q.pop_front());
			void'(nb_q.pop_front());
		end
	end
	// Main sequence
	initial begin
		raw = $random(seed);
		temp = $random(seed);
		lvl = $random(seed);
		prod = raw * 32'sh7333;
		cfg = mode_t'(8'($random(seed)) & 8'hf7);
		cfg2 = mode_t'(8'($random(seed)) & 8'hf7);
		repeat (8) @(posedge clk_i);
		#1 rst_i = 1'b0;
		repeat (60) @(posedge clk_i);
		frame(2, 0, cfg, 8'h05);
		for (int i = 0; i < 400 && settled !== 1'b1; i++) @(posedge clk_i);
		check("settled", settled, 1'b1);
		if (settled !== 1'b1) final_report();
		// First update tick raises the ready pin and fills the buffer
		for (int i = 0; i < 1000 && ready !== 1'b1; i++) @(negedge clk_i);
		check("ready", ready, 1'b1);
		if (ready !== 1'b1) final_report();
		frame(22, 1, cfg2, 8'h03);
		check("ready", ready, 1'b0);
		check("mode", cfg_o, MODE_RESET);
		frame(5, 1, cfg2, 8'h00);
		check("mode", cfg_o, cfg);
		frame(4, 1, cfg2, 8'h01);
		check("mode", cfg_o, cfg2);
		// Arm the watchdog, then stay quiet until it resets the device
		for (int k = 0; k < 3; k++) frame(2, 1, 8'h08, 8'h00);
		check("mode", cfg_o, 8'h08);
		for (int i = 0; i < 400 && wdrst !== 1'b1; i++) @(negedge clk_i);
		check("self reset", wdrst, 1'b1);
		@(negedge clk_i);
		check("mode", cfg_o, MODE_RESET);
		repeat (5) @(posedge clk_i);
		final_report();
	end
endmodule
